// [smr_defs.vh]
// Constants for the sideband management command responder.
// Assumes header parsing, checksum and generic response codes are handled elsewhere.
`ifndef SMR_DEFS_VH
`define SMR_DEFS_VH

// ----------------------------------------
// Command and response codes
// ----------------------------------------
`define SMR_CMD_QRY_PLDM 8'h56
`define SMR_CMD_PLDM_REPLY 8'h57
`define SMR_CMD_GET_MAC 8'h58
`define SMR_CMD_SPDM 8'h60
`define SMR_RSP_BIT 8'h80
`define SMR_RSP_PLDM_REPLY 8'hd7
`define SMR_RSP_GET_MAC 8'hd8
`define SMR_RSP_SPDM 8'he0

// ----------------------------------------
// Packet layout and table sizes
// ----------------------------------------
`define SMR_RSP_PAYLOAD_BYTE 20
`define SMR_WORD_BYTES 3'h4
`define SMR_MAC_BYTES 3'h6
`define SMR_MAC_LAST_BYTE 3'h5
`define SMR_PAD_BYTES 2'h2
`define SMR_FLAG_PENDING_BIT 0
`define SMR_CHAN_W 2
`define SMR_IDX_W 2
`define SMR_CNT_W 3
`define SMR_MAC_W 48

`endif

// [smr_mac_table.v]
// Table of management MAC addresses provisioned per channel.
// Assumes the provisioning agent writes entries and counts while the table is idle.
`timescale 1ns/10ps
`include "smr_defs.vh"

module smr_mac_table (
  input wire clk_in,
  input wire resetn_in,
  input wire wr_en_in,
  input wire [`SMR_CHAN_W-1:0] wr_chan_in,
  input wire [`SMR_IDX_W-1:0] wr_idx_in,
  input wire [`SMR_MAC_W-1:0] wr_mac_in,
  input wire cnt_wr_en_in,
  input wire [`SMR_CNT_W-1:0] cnt_in,
  input wire [`SMR_CHAN_W-1:0] rd_chan_in,
  input wire [`SMR_IDX_W-1:0] rd_idx_in,
  output wire [`SMR_MAC_W-1:0] rd_mac_out,
  output wire [`SMR_CNT_W-1:0] rd_cnt_out
);

  localparam NCH = 1 << `SMR_CHAN_W;
  localparam NENT = 1 << (`SMR_CHAN_W + `SMR_IDX_W);

  reg [`SMR_MAC_W-1:0] mac_q [0:NENT-1];
  reg [`SMR_CNT_W-1:0] cnt_q [0:NCH-1];
  integer i;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (i = 0; i < NENT; i = i + 1)
        mac_q[i] <= {`SMR_MAC_W{1'b0}};
      for (i = 0; i < NCH; i = i + 1)
        cnt_q[i] <= {`SMR_CNT_W{1'b0}};
    end
    else
    begin
      if (wr_en_in)
        mac_q[{wr_chan_in, wr_idx_in}] <= wr_mac_in;
      if (cnt_wr_en_in)
        cnt_q[wr_chan_in] <= cnt_in;
    end
  end

  assign rd_mac_out = mac_q[{rd_chan_in, rd_idx_in}];
  assign rd_cnt_out = cnt_q[rd_chan_in];

endmodule // smr_mac_table

// [smr_responder.v]
// Command handler for pending PLDM requests, PLDM replies, MAC discovery and SPDM.
// Assumes a header parser delivering command code, channel and payload bytes from byte 16,
// and a downstream builder taking one response byte per cycle from byte 20 with no stall.
//
// Notes on behaviour
// - Pending-request answer carries PLDM common fields and payload from byte 20, only if pending.
// - Without a pending request the query completes successfully with no PLDM payload.
// - One query conveys exactly one PLDM request; the device picks the order.
// - Send-reply is package scope; the channel field plays no part.
// - Send-reply response 0xD7 has flags in byte 23; bit 0 is another request pending.
// - MAC discovery 0x58 is per channel, reporting only that channel's host addresses.
// - MAC discovery is always accepted without error and answered with code 0xD8.
// - Address count in upper half of word 20-23 holds the provisioned count.
// - Reserved half beside the address count is driven zero; the host ignores it.
// - Each address goes out as six bytes, byte 5 first, packed without gaps.
// - Odd address count appends two zero pad bytes; even count appends none.
// - Oversized SPDM messages use SPDM multi-part transfer, device parts fetched by polling.
// - SPDM command and response are unsupported when carried over MCTP.
// - Error-free SPDM command answered 0xE0: fields in bytes 20-23, payload from 24.
`timescale 1ns/10ps
`include "smr_defs.vh"

module smr_responder (
  input wire clk_in,
  input wire resetn_in,
  input wire cmd_valid_in,
  input wire [7:0] cmd_code_in,
  input wire [`SMR_CHAN_W-1:0] cmd_chan_in,
  input wire cmd_err_in,
  input wire cmd_byte_valid_in,
  input wire [7:0] cmd_byte_in,
  input wire cmd_byte_last_in,
  input wire over_mctp_in,
  input wire pldm_pending_in,
  input wire pldm_req_valid_in,
  input wire [7:0] pldm_req_byte_in,
  input wire pldm_req_last_in,
  input wire spdm_rx_valid_in,
  input wire [7:0] spdm_rx_byte_in,
  input wire spdm_rx_last_in,
  input wire prov_wr_en_in,
  input wire [`SMR_CHAN_W-1:0] prov_chan_in,
  input wire [`SMR_IDX_W-1:0] prov_idx_in,
  input wire [`SMR_MAC_W-1:0] prov_mac_in,
  input wire prov_cnt_wr_en_in,
  input wire [`SMR_CNT_W-1:0] prov_cnt_in,
  output reg busy_out,
  output reg pldm_pop_out,
  output reg pldm_rsp_valid_out,
  output reg [7:0] pldm_rsp_byte_out,
  output reg pldm_rsp_last_out,
  output reg spdm_tx_valid_out,
  output reg [7:0] spdm_tx_byte_out,
  output reg spdm_tx_last_out,
  output reg rsp_start_out,
  output reg [7:0] rsp_code_out,
  output reg rsp_unsupported_out,
  output reg rsp_valid_out,
  output reg [7:0] rsp_byte_out,
  output reg rsp_last_out,
  output reg rsp_done_out
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_PLDM_Q = 4'h1;
  localparam [3:0] ST_PLDM_R = 4'h2;
  localparam [3:0] ST_FLAGS = 4'h3;
  localparam [3:0] ST_MAC_HDR = 4'h4;
  localparam [3:0] ST_MAC_ADR = 4'h5;
  localparam [3:0] ST_MAC_PAD = 4'h6;
  localparam [3:0] ST_SPDM_TX = 4'h7;
  localparam [3:0] ST_SPDM_RX = 4'h8;
  localparam [3:0] ST_DONE = 4'h9;

  reg [3:0] state_q;
  reg [2:0] cnt_q;
  reg [`SMR_IDX_W-1:0] adr_q;
  reg [`SMR_CHAN_W-1:0] chan_q;
  reg [7:0] flags_q;
  wire [`SMR_MAC_W-1:0] mac_w;
  wire [`SMR_CNT_W-1:0] mac_cnt_w;

  // Byte j of an address, byte 5 being the most significant
  function [7:0] mac_byte;
    input [`SMR_MAC_W-1:0] mac;
    input [2:0] j;
    begin
      mac_byte = mac[j*8 +: 8];
    end
  endfunction

  smr_mac_table u_table (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(prov_wr_en_in),
    .wr_chan_in(prov_chan_in),
    .wr_idx_in(prov_idx_in),
    .wr_mac_in(prov_mac_in),
    .cnt_wr_en_in(prov_cnt_wr_en_in),
    .cnt_in(prov_cnt_in),
    .rd_chan_in(chan_q),
    .rd_idx_in(adr_q),
    .rd_mac_out(mac_w),
    .rd_cnt_out(mac_cnt_w)
  );

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      adr_q <= {`SMR_IDX_W{1'b0}};
      chan_q <= {`SMR_CHAN_W{1'b0}};
      flags_q <= 8'h00;
      busy_out <= 1'b0;
      pldm_pop_out <= 1'b0;
      pldm_rsp_valid_out <= 1'b0;
      pldm_rsp_byte_out <= 8'h00;
      pldm_rsp_last_out <= 1'b0;
      spdm_tx_valid_out <= 1'b0;
      spdm_tx_byte_out <= 8'h00;
      spdm_tx_last_out <= 1'b0;
      rsp_start_out <= 1'b0;
      rsp_code_out <= 8'h00;
      rsp_unsupported_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_byte_out <= 8'h00;
      rsp_last_out <= 1'b0;
      rsp_done_out <= 1'b0;
    end
    else
    begin
      pldm_pop_out <= 1'b0;
      pldm_rsp_valid_out <= 1'b0;
      pldm_rsp_last_out <= 1'b0;
      spdm_tx_valid_out <= 1'b0;
      spdm_tx_last_out <= 1'b0;
      rsp_start_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_last_out <= 1'b0;
      rsp_done_out <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          rsp_unsupported_out <= 1'b0;
          // Commands with checksum or identifier errors are dropped without an answer
          if (cmd_valid_in && !cmd_err_in)
          begin
            rsp_code_out <= cmd_code_in | `SMR_RSP_BIT;
            cnt_q <= 3'h0;
            adr_q <= {`SMR_IDX_W{1'b0}};
            case (cmd_code_in)
              `SMR_CMD_QRY_PLDM:
              begin
                busy_out <= 1'b1;
                rsp_start_out <= 1'b1;
                if (pldm_pending_in)
                begin
                  pldm_pop_out <= 1'b1;
                  state_q <= ST_PLDM_Q;
                end
                else
                  state_q <= ST_DONE;
              end
              `SMR_CMD_PLDM_REPLY:
              begin
                busy_out <= 1'b1;
                rsp_start_out <= 1'b1;
                state_q <= ST_PLDM_R;
              end
              `SMR_CMD_GET_MAC:
              begin
                busy_out <= 1'b1;
                rsp_start_out <= 1'b1;
                chan_q <= cmd_chan_in;
                state_q <= ST_MAC_HDR;
              end
              `SMR_CMD_SPDM:
              begin
                busy_out <= 1'b1;
                rsp_start_out <= 1'b1;
                // Payload bytes are still drained so the parser never stalls
                rsp_unsupported_out <= over_mctp_in;
                state_q <= ST_SPDM_TX;
              end
              default:
              begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_PLDM_Q:
        begin
          // Request bytes, common fields first, land at response byte 20 onward
          if (pldm_req_valid_in)
          begin
            rsp_valid_out <= 1'b1;
            rsp_byte_out <= pldm_req_byte_in;
            rsp_last_out <= pldm_req_last_in;
            if (pldm_req_last_in)
              state_q <= ST_DONE;
          end
        end
        ST_PLDM_R:
        begin
          if (cmd_byte_valid_in)
          begin
            pldm_rsp_valid_out <= 1'b1;
            pldm_rsp_byte_out <= cmd_byte_in;
            pldm_rsp_last_out <= cmd_byte_last_in;
            if (cmd_byte_last_in)
              state_q <= ST_FLAGS;
          end
        end
        ST_FLAGS:
        begin
          // Three reserved bytes, then the flags byte in the low lane of word 20-23
          if (cnt_q == 3'h0)
          begin
            flags_q <= 8'h00;
            flags_q[`SMR_FLAG_PENDING_BIT] <= pldm_pending_in;
          end
          rsp_valid_out <= 1'b1;
          rsp_byte_out <= (cnt_q == `SMR_WORD_BYTES - 3'h1) ? flags_q : 8'h00;
          if (cnt_q == `SMR_WORD_BYTES - 3'h1)
          begin
            rsp_last_out <= 1'b1;
            state_q <= ST_DONE;
          end
          cnt_q <= cnt_q + 3'h1;
        end
        ST_MAC_HDR:
        begin
          rsp_valid_out <= 1'b1;
          // Count is only 3 bits wide inside the 16-bit field, so its upper byte is always zero
          rsp_byte_out <= (cnt_q == 3'h1) ? {{(8-`SMR_CNT_W){1'b0}}, mac_cnt_w} : 8'h00;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `SMR_WORD_BYTES - 3'h1)
          begin
            cnt_q <= 3'h0;
            if (mac_cnt_w == {`SMR_CNT_W{1'b0}})
            begin
              rsp_last_out <= 1'b1;
              state_q <= ST_DONE;
            end
            else
              state_q <= ST_MAC_ADR;
          end
        end
        ST_MAC_ADR:
        begin
          rsp_valid_out <= 1'b1;
          rsp_byte_out <= mac_byte(mac_w, `SMR_MAC_LAST_BYTE - cnt_q);
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `SMR_MAC_BYTES - 3'h1)
          begin
            cnt_q <= 3'h0;
            adr_q <= adr_q + {{(`SMR_IDX_W-1){1'b0}}, 1'b1};
            if ({1'b0, adr_q} + {`SMR_CNT_W{1'b0}} + 3'h1 == mac_cnt_w)
            begin
              if (mac_cnt_w[0])
                state_q <= ST_MAC_PAD;
              else
              begin
                rsp_last_out <= 1'b1;
                state_q <= ST_DONE;
              end
            end
          end
        end
        ST_MAC_PAD:
        begin
          rsp_valid_out <= 1'b1;
          rsp_byte_out <= 8'h00;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == {1'b0, `SMR_PAD_BYTES} - 3'h1)
          begin
            rsp_last_out <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_SPDM_TX:
        begin
          if (cmd_byte_valid_in)
          begin
            spdm_tx_valid_out <= !rsp_unsupported_out;
            spdm_tx_byte_out <= cmd_byte_in;
            spdm_tx_last_out <= cmd_byte_last_in && !rsp_unsupported_out;
            if (cmd_byte_last_in)
              state_q <= rsp_unsupported_out ? ST_DONE : ST_SPDM_RX;
          end
        end
        ST_SPDM_RX:
        begin
          // No timeout: the engine may take a long time on some tasks
          if (spdm_rx_valid_in)
          begin
            // Each part of a multi-part message is one command and one answer
            rsp_valid_out <= 1'b1;
            rsp_byte_out <= spdm_rx_byte_in;
            rsp_last_out <= spdm_rx_last_in;
            if (spdm_rx_last_in)
              state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          rsp_done_out <= 1'b1;
          busy_out <= 1'b0;
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // smr_responder

// [smr_monitor.sv]
// Port checker for the sideband command responder.
// Assumes one clock domain; bound to every smr_responder instance.
`timescale 1ns/10ps
module smr_monitor (
  input wire clk_in,
  input wire resetn_in,
  input wire cmd_valid_in,
  input wire [7:0] cmd_code_in,
  input wire cmd_err_in,
  input wire pldm_pending_in,
  input wire pldm_req_valid_in,
  input wire [7:0] pldm_req_byte_in,
  input wire spdm_rx_valid_in,
  input wire [7:0] spdm_rx_byte_in,
  input wire busy_out,
  input wire pldm_pop_out,
  input wire spdm_tx_valid_out,
  input wire rsp_start_out,
  input wire [7:0] rsp_code_out,
  input wire rsp_unsupported_out,
  input wire rsp_valid_out,
  input wire [7:0] rsp_byte_out,
  input wire rsp_last_out,
  input wire rsp_done_out
);
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  wire tk = cmd_valid_in && !cmd_err_in && !busy_out;
  wire known = cmd_code_in inside {8'h56, 8'h57, 8'h58, 8'h60};
  // Remembers a pop so a second one in the same command is caught
  reg popped_q;
  always @(posedge clk_in or negedge resetn_in)
    if (!resetn_in) popped_q <= 1'b0;
    else if (rsp_done_out) popped_q <= 1'b0;
    else if (pldm_pop_out) popped_q <= 1'b1;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  property p_start;
    tk && known |=> rsp_start_out && busy_out && rsp_code_out == ($past(cmd_code_in) | 8'h80);
  endproperty
  a_start: assert property (p_start) else $error("no start or wrong code");
  property p_refuse;
    cmd_valid_in && !busy_out && (cmd_err_in || !known) |=> !rsp_start_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused command answered");
  property p_req_fwd;
    rsp_valid_out && rsp_code_out == 8'hd6 |-> $past(pldm_req_valid_in) && rsp_byte_out == $past(pldm_req_byte_in);
  endproperty
  a_req_fwd: assert property (p_req_fwd) else $error("request byte not forwarded");
  property p_empty;
    tk && cmd_code_in == 8'h56 && !pldm_pending_in |=> rsp_start_out && !rsp_valid_out ##1 rsp_done_out && !rsp_valid_out;
  endproperty
  a_empty: assert property (p_empty) else $error("empty query wrong");
  property p_pop;
    pldm_pop_out |-> !popped_q && $past(pldm_pending_in);
  endproperty
  a_pop: assert property (p_pop) else $error("extra or unprompted pop");
  property p_flags;
    rsp_valid_out && rsp_last_out && rsp_code_out == 8'hd7 |-> rsp_byte_out == {7'h0, $past(pldm_pending_in, 4)};
  endproperty
  a_flags: assert property (p_flags) else $error("reply flags wrong");
  property p_unsup;
    rsp_unsupported_out |-> !rsp_valid_out && !spdm_tx_valid_out && rsp_code_out == 8'he0;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported command forwarded");
  property p_spdm;
    rsp_valid_out && rsp_code_out == 8'he0 |-> $past(spdm_rx_valid_in) && rsp_byte_out == $past(spdm_rx_byte_in);
  endproperty
  a_spdm: assert property (p_spdm) else $error("spdm answer not forwarded");
  property p_done;
    rsp_valid_out && rsp_last_out |=> rsp_done_out && !rsp_valid_out;
  endproperty
  a_done: assert property (p_done) else $error("done not after last byte");
endmodule // smr_monitor
bind smr_responder smr_monitor u_smr_monitor (.*);

// [smr_host_model.sv]
// Management host model: issues commands and command bytes.
// Assumes the responder takes a command only while idle.
`timescale 1ns/10ps
module smr_host_model (
  input wire clk_in,
  input wire busy_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_code_out,
  output logic [1:0] cmd_chan_out,
  output logic cmd_err_out,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  output logic byte_last_out
);
  // ----------------------------------------
  // Command issue
  // ----------------------------------------
  initial {cmd_valid_out, cmd_code_out, cmd_chan_out, cmd_err_out, byte_valid_out, byte_out, byte_last_out} = '0;
  task automatic issue(input logic [7:0] code, input logic [1:0] chan, input logic err, input logic [7:0] b[$]);
    for (int t = 0; t < 1000 && busy_in !== 1'b0; t++) @(negedge clk_in);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_code_out = code;
    cmd_chan_out = chan;
    cmd_err_out = err;
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    // Released code and byte lines toggle so a stale value is never mistaken for data
    cmd_code_out = ~code;
    foreach (b[i])
    begin
      byte_out = b[i];
      byte_valid_out = 1'b1;
      byte_last_out = i == b.size() - 1;
      @(negedge clk_in);
    end
    byte_valid_out = 1'b0;
    byte_last_out = 1'b0;
    byte_out = ~byte_out;
  endtask
endmodule // smr_host_model

// [smr_responder_tb.sv]
// Self-checking bench for the sideband command responder.
// Assumes the host model issues commands; engines and provisioning are driven here.
`timescale 1ns/10ps
module smr_responder_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic over_mctp_in, pldm_pending_in, pldm_req_valid_in, pldm_req_last_in, spdm_rx_valid_in, spdm_rx_last_in;
  logic prov_wr_en_in, prov_cnt_wr_en_in;
  logic [7:0] pldm_req_byte_in, spdm_rx_byte_in;
  logic [1:0] prov_chan_in, prov_idx_in;
  logic [47:0] prov_mac_in;
  logic [2:0] prov_cnt_in;
  wire cmd_valid_in, cmd_err_in, cmd_byte_valid_in, cmd_byte_last_in;
  wire [7:0] cmd_code_in, cmd_byte_in;
  wire [1:0] cmd_chan_in;
  wire busy_out, pldm_pop_out, pldm_rsp_valid_out, pldm_rsp_last_out, spdm_tx_valid_out, spdm_tx_last_out;
  wire rsp_start_out, rsp_unsupported_out, rsp_valid_out, rsp_last_out, rsp_done_out;
  wire [7:0] pldm_rsp_byte_out, spdm_tx_byte_out, rsp_code_out, rsp_byte_out;
  int n_fail = 0;
  int check_count = 0;
  int cnt[4] = '{0, 1, 4, 3};
  logic [31:0] rs = 32'd90;
  logic [47:0] mt[4][4];
  logic [7:0] nb[$];
  logic [9:0] q[4][$];
  always #12.5 clk_in = ~clk_in;
  smr_responder u_smr_responder (.*);
  smr_host_model u_smr_host_model (.clk_in(clk_in), .busy_in(busy_out), .cmd_valid_out(cmd_valid_in),
    .cmd_code_out(cmd_code_in), .cmd_chan_out(cmd_chan_in), .cmd_err_out(cmd_err_in),
    .byte_valid_out(cmd_byte_valid_in), .byte_out(cmd_byte_in), .byte_last_out(cmd_byte_last_in));
  // ----------------------------------------
  // Helpers and output watcher
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic cmp(input string s, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic ex(input int k, input logic [9:0] e);
    q[k].push_back(e);
  endtask
  // Separate notes per stream: forwarded and response bytes may coincide
  wire [3:0] v = {rsp_start_out, spdm_tx_valid_out, pldm_rsp_valid_out, rsp_valid_out};
  wire [9:0] a[4];
  assign a[0] = {rsp_unsupported_out, rsp_last_out, rsp_byte_out};
  assign a[1] = {1'b0, pldm_rsp_last_out, pldm_rsp_byte_out};
  assign a[2] = {1'b0, spdm_tx_last_out, spdm_tx_byte_out};
  assign a[3] = {rsp_unsupported_out, 1'b0, rsp_code_out};
  always @(negedge clk_in)
    for (int k = 0; k < 4; k++)
      if (v[k] !== 1'b0)
        cmp($sformatf("stream %0d", k), q[k].size() ? q[k].pop_front() : 10'h3ff, a[k]);
  task automatic fin(input string s);
    int t;
    t = 0;
    while (rsp_done_out !== 1'b1 && t < 1000)
    begin
      @(negedge clk_in);
      t++;
    end
    cmp("done", 10'h1, {9'h0, rsp_done_out});
    repeat (2) @(negedge clk_in);
    for (int k = 0; k < 4; k++)
      cmp("notes left", 10'h0, 10'(q[k].size()));
    $display("test %s finished", s);
  endtask
  task automatic feed(ref logic vl, ref logic [7:0] d, ref logic l, input int n);
    for (int i = 0; i < n; i++)
    begin
      d = 8'(rnd());
      vl = 1'b1;
      l = i == n - 1;
      ex(0, {1'b0, l, d});
      @(negedge clk_in);
    end
    vl = 1'b0;
    l = 1'b0;
    d = ~d;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic getmac(input int c);
    int n;
    n = cnt[c];
    ex(3, 10'h0d8);
    for (int i = 0; i < 4; i++)
      ex(0, {1'b0, n == 0 && i == 3, i == 1 ? 8'(n) : 8'h00});
    for (int i = 0; i < n * 6; i++)
      ex(0, {1'b0, n % 2 == 0 && i == n * 6 - 1, mt[c][i / 6][47 - 8 * (i % 6) -: 8]});
    for (int i = 0; i < 2 * (n % 2); i++)
      ex(0, {1'b0, i == 1, 8'h00});
    u_smr_host_model.issue(8'h58, 2'(c), 1'b0, nb);
    fin("mac discovery");
  endtask
  task automatic query(input int n);
    pldm_pending_in = n != 0;
    ex(3, 10'h0d6);
    u_smr_host_model.issue(8'h56, 2'(rnd()), 1'b0, nb);
    // The pop pulse stands in the cycle right after the command edge
    cmp("pop", {9'h0, n != 0}, {9'h0, pldm_pop_out});
    feed(pldm_req_valid_in, pldm_req_byte_in, pldm_req_last_in, n);
    fin("pending query");
  endtask
  task automatic reply(input logic p, input int n);
    logic [7:0] b[$];
    pldm_pending_in = p;
    ex(3, 10'h0d7);
    for (int i = 0; i < n; i++)
    begin
      b.push_back(8'(rnd()));
      ex(1, {1'b0, i == n - 1, b[i]});
    end
    for (int i = 0; i < 4; i++)
      ex(0, {1'b0, i == 3, i == 3 ? {7'h0, p} : 8'h00});
    u_smr_host_model.issue(8'h57, 2'(rnd()), 1'b0, b);
    fin("send reply");
  endtask
  task automatic spdm(input logic m, input int n, input int r);
    logic [7:0] b[$];
    over_mctp_in = m;
    ex(3, {m, 9'h0e0});
    for (int i = 0; i < n; i++)
    begin
      b.push_back(8'(rnd()));
      if (!m) ex(2, {1'b0, i == n - 1, b[i]});
    end
    u_smr_host_model.issue(8'h60, 2'(rnd()), 1'b0, b);
    // A slow engine stands for a long-running task
    if (!m) repeat (40) @(negedge clk_in);
    if (!m) feed(spdm_rx_valid_in, spdm_rx_byte_in, spdm_rx_last_in, r);
    fin("spdm");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    {over_mctp_in, pldm_pending_in, pldm_req_valid_in, pldm_req_last_in, spdm_rx_valid_in, spdm_rx_last_in,
      prov_wr_en_in, prov_cnt_wr_en_in, pldm_req_byte_in, spdm_rx_byte_in, prov_chan_in, prov_idx_in,
      prov_mac_in, prov_cnt_in} = '0;
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      prov_chan_in = 2'(c);
      prov_cnt_in = 3'(cnt[c]);
      prov_cnt_wr_en_in = 1'b1;
      @(negedge clk_in);
      prov_cnt_wr_en_in = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
        mt[c][i] = 48'({rnd(), rnd()});
        prov_idx_in = 2'(i);
        prov_mac_in = mt[c][i];
        prov_wr_en_in = 1'b1;
        @(negedge clk_in);
      end
      prov_wr_en_in = 1'b0;
    end
    for (int c = 0; c < 4; c++)
      getmac(c);
    query(0);
    query(6);
    reply(1'b1, 4);
    query(5);
    reply(1'b0, 9);
    spdm(1'b0, 6, 7);
    spdm(1'b1, 5, 0);
    over_mctp_in = 1'b0;
    u_smr_host_model.issue(8'h58, 2'h1, 1'b1, nb);
    u_smr_host_model.issue(8'h55, 2'h1, 1'b0, nb);
    repeat (6) @(negedge clk_in);
    $display("test refusal finished");
    test_done();
  end
  initial
  begin
    #100us;
    cmp("watchdog", 10'h1, 10'h0);
    test_done();
  end
endmodule // smr_responder_tb
